/* hdl/bit_sync.sv */
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level that may be sampled in any order.
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage1_d;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage2_d;

  always_comb begin
    stage1_d = i_async;
    stage2_d = stage1_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      stage1_q <= RST_VAL;
      stage2_q <= RST_VAL;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign o_sync = stage2_q;
endmodule
`default_nettype wire

/* hdl/gain_fwd_pkg.sv */
// Constants, register map and link state type for the gain stage forwarder.
// Assumes a 125 MHz main clock and a free running forwarding oscillator.
package gain_fwd_pkg;

  // Serial register frame
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int WORD_BITS = 40;

  // Register addresses
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_GAIN_RESET_CTRL = 8'h03;
  localparam logic [7:0] ADDR_GAIN_LOW = 8'h16;
  localparam logic [7:0] ADDR_GAIN_MID = 8'h17;
  localparam logic [7:0] ADDR_GAIN_HIGH = 8'h18;

  // Field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int FWD_RESET_BIT = 5;
  localparam int MODE_BIT = 5;

  // Reset values and masks
  localparam logic [15:0] GAIN_LOW_RST = 16'h0023;
  localparam logic [15:0] GAIN_MID_RST = 16'h0000;
  localparam logic [15:0] GAIN_HIGH_RST = 16'h0000;
  localparam logic [15:0] GAIN_LOW_FORCE = 16'h0003;
  localparam logic [15:0] GAIN_HIGH_MASK = 16'h00ff;

  // Serial bit counts at which fields complete
  localparam logic [5:0] FRAME_ADDR_END = 6'h08;
  localparam logic [5:0] FRAME_WORD1_END = 6'h18;
  localparam logic [5:0] FRAME_WORD2_END = 6'h28;
  localparam logic [5:0] FRAME_WORD3_END = 6'h30;
  localparam logic [5:0] FRAME_CNT_MAX = 6'h3f;

  // Timing
  localparam int MCLK_MHZ = 125;
  localparam int ADC_RST_MIN_NS = 10;
  localparam int ADC_RST_MIN_CYC = (ADC_RST_MIN_NS * MCLK_MHZ + 999) / 1000;
  localparam int FWD_OSC_KHZ = 6000;
  localparam logic [3:0] PIN_LOW_CNT_MAX = 4'hf;

  // Link shifter
  localparam logic [5:0] LINK_LAST_BIT = 6'h27;

  typedef enum logic {
    LINK_IDLE = 1'b0,
    LINK_SHIFT = 1'b1
  } link_state_t;

endpackage

/* hdl/gain_stage_shadow_forwarder.sv */
// Serial register bank holding the gain stage word and forwarding it on a gated link.
// Assumes a three-wire host port far slower than the main clock and a free running
// forwarding oscillator near 6 MHz on its own clock input.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Soft reset bit resets registers, self-clears
// - Three registers hold forty forwarded bits
// - Forwarded bits zero and one always one
// - Link idle unless gain registers written
// - Any gain write that changes contents sends whole word
// - Only changed contents start a transfer
// - Oscillator gated, runs only while shifting
// - Select high on pin reset or bit
// - Forward reset restores gain register defaults
// - No link toggling during forward reset
// - Forwarder held reset while bit set
// - Start and write bits always one
// - Bit five selects mode, default one
module gain_stage_shadow_forwarder (
  // Main clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Host serial port
  input wire logic i_sen_n,
  input wire logic i_sclk,
  input wire logic i_sdata,
  // Converter reset pin
  input wire logic i_adc_reset_n,
  // Forwarding oscillator
  input wire logic i_fwd_osc,
  // Forwarding link
  output logic o_forward_link_clock,
  output logic o_forward_link_data,
  output logic o_forward_link_select,
  // Status
  output logic o_forward_busy,
  output logic o_time_gain_mode,
  output logic [gain_fwd_pkg::WORD_BITS-1:0] o_gain_word
);
  import gain_fwd_pkg::*;

  localparam logic [3:0] ADC_RST_CYC = 4'(ADC_RST_MIN_CYC);

  // Pin synchronisers
  logic [3:0] pin_s;
  logic sclk_s;
  logic sen_n_s;
  logic sdata_s;
  logic adc_rst_n_s;

  bit_sync #(.WIDTH(4), .RST_VAL(4'ha)) u_pin_sync (
    .i_clk(i_mclk),
    .i_nrst(i_nrst),
    .i_async({i_adc_reset_n, i_sdata, i_sen_n, i_sclk}),
    .o_sync(pin_s)
  );

  assign sclk_s = pin_s[0];
  assign sen_n_s = pin_s[1];
  assign sdata_s = pin_s[2];
  assign adc_rst_n_s = pin_s[3];

  // Serial frame state
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic [5:0] bit_cnt_q;
  logic [5:0] bit_cnt_d;
  logic [5:0] cnt_inc;
  logic [ADDR_BITS-1:0] addr_q;
  logic [ADDR_BITS-1:0] addr_d;
  logic [DATA_BITS-1:0] shift_q;
  logic [DATA_BITS-1:0] shift_d;
  logic wr_en;
  logic [ADDR_BITS-1:0] wr_addr;
  logic [DATA_BITS-1:0] wr_data;

  always_comb begin
    sclk_prev_d = sclk_s;
    bit_cnt_d = bit_cnt_q;
    addr_d = addr_q;
    shift_d = shift_q;
    wr_en = 1'b0;
    wr_addr = addr_q;
    wr_data = '0;
    cnt_inc = bit_cnt_q + 6'h01;
    if (sen_n_s) begin
      bit_cnt_d = 6'h00;
    end else if (sclk_s && !sclk_prev_q && (bit_cnt_q != FRAME_CNT_MAX)) begin
      bit_cnt_d = cnt_inc;
      if (cnt_inc <= FRAME_ADDR_END) begin
        addr_d = {addr_q[ADDR_BITS-2:0], sdata_s};
      end else begin
        shift_d = {shift_q[DATA_BITS-2:0], sdata_s};
      end
      if (cnt_inc == FRAME_WORD1_END) begin
        wr_en = 1'b1;
        wr_data = {shift_q[DATA_BITS-2:0], sdata_s};
      end else if ((addr_q == ADDR_GAIN_LOW) && (cnt_inc == FRAME_WORD2_END)) begin
        wr_en = 1'b1;
        wr_addr = ADDR_GAIN_MID;
        wr_data = {shift_q[DATA_BITS-2:0], sdata_s};
      end else if ((addr_q == ADDR_GAIN_LOW) && (cnt_inc == FRAME_WORD3_END)) begin
        wr_en = 1'b1;
        wr_addr = ADDR_GAIN_HIGH;
        wr_data = {8'h00, shift_q[6:0], sdata_s};
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= 6'h00;
      addr_q <= '0;
      shift_q <= '0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      bit_cnt_q <= bit_cnt_d;
      addr_q <= addr_d;
      shift_q <= shift_d;
    end
  end

  // Register bank and forwarding control
  logic sw_rst_q;
  logic sw_rst_d;
  logic res_bit_q;
  logic res_bit_d;
  logic [DATA_BITS-1:0] gain_low_q;
  logic [DATA_BITS-1:0] gain_low_d;
  logic [DATA_BITS-1:0] gain_mid_q;
  logic [DATA_BITS-1:0] gain_mid_d;
  logic [DATA_BITS-1:0] gain_high_q;
  logic [DATA_BITS-1:0] gain_high_d;
  logic [3:0] pin_low_cnt_q;
  logic [3:0] pin_low_cnt_d;
  logic fwd_rst_q;
  logic fwd_rst_d;
  logic link_run_q;
  logic link_run_d;
  logic pending_q;
  logic pending_d;
  logic req_q;
  logic req_d;
  logic [WORD_BITS-1:0] snap_q;
  logic [WORD_BITS-1:0] snap_d;
  logic [DATA_BITS-1:0] low_val;
  logic [DATA_BITS-1:0] high_val;
  logic changed;
  logic start;
  logic ack_s;
  logic busy;

  assign busy = (req_q != ack_s);

  always_comb begin
    sw_rst_d = 1'b0;
    res_bit_d = res_bit_q;
    gain_low_d = gain_low_q;
    gain_mid_d = gain_mid_q;
    gain_high_d = gain_high_q;
    pin_low_cnt_d = pin_low_cnt_q;
    req_d = req_q;
    snap_d = snap_q;
    changed = 1'b0;
    start = 1'b0;
    low_val = wr_data | GAIN_LOW_FORCE;
    high_val = wr_data & GAIN_HIGH_MASK;

    // Low pulse on the converter reset pin must outlast the minimum width
    if (adc_rst_n_s) begin
      pin_low_cnt_d = 4'h0;
    end else if (pin_low_cnt_q != PIN_LOW_CNT_MAX) begin
      pin_low_cnt_d = pin_low_cnt_q + 4'h1;
    end
    fwd_rst_d = res_bit_q | (pin_low_cnt_q >= ADC_RST_CYC);

    // Self-clearing: only a write sets it, so it lasts one cycle
    if (wr_en && (wr_addr == ADDR_SOFT_RESET)) begin
      sw_rst_d = wr_data[SOFT_RESET_BIT];
    end

    if (sw_rst_q) begin
      res_bit_d = 1'b0;
      gain_low_d = GAIN_LOW_RST;
      gain_mid_d = GAIN_MID_RST;
      gain_high_d = GAIN_HIGH_RST;
    end else if (fwd_rst_q) begin
      // Gain writes are dropped while the forwarder sits in reset
      if (wr_en && (wr_addr == ADDR_GAIN_RESET_CTRL)) begin
        res_bit_d = wr_data[FWD_RESET_BIT];
      end
      gain_low_d = GAIN_LOW_RST;
      gain_mid_d = GAIN_MID_RST;
      gain_high_d = GAIN_HIGH_RST;
    end else if (wr_en) begin
      if (wr_addr == ADDR_GAIN_RESET_CTRL) begin
        res_bit_d = wr_data[FWD_RESET_BIT];
      end else if (wr_addr == ADDR_GAIN_LOW) begin
        if (low_val != gain_low_q) begin
          gain_low_d = low_val;
          changed = 1'b1;
        end
      end else if (wr_addr == ADDR_GAIN_MID) begin
        if (wr_data != gain_mid_q) begin
          gain_mid_d = wr_data;
          changed = 1'b1;
        end
      end else if (wr_addr == ADDR_GAIN_HIGH) begin
        if (high_val != gain_high_q) begin
          gain_high_d = high_val;
          changed = 1'b1;
        end
      end
    end

    // Only gain register changes ever raise a request
    start = pending_q && !busy && !fwd_rst_q && !sw_rst_q;
    if (fwd_rst_q) begin
      req_d = 1'b0;
    end else if (start) begin
      snap_d = {gain_high_q[7:0], gain_mid_q, gain_low_q | GAIN_LOW_FORCE};
      req_d = ~req_q;
    end

    // A change arriving as the queue drains wins over the clear
    if (fwd_rst_q || sw_rst_q) begin
      pending_d = 1'b0;
    end else begin
      pending_d = (pending_q & ~start) | changed;
    end

    link_run_d = ~fwd_rst_d;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sw_rst_q <= 1'b0;
      res_bit_q <= 1'b0;
      gain_low_q <= GAIN_LOW_RST;
      gain_mid_q <= GAIN_MID_RST;
      gain_high_q <= GAIN_HIGH_RST;
      pin_low_cnt_q <= 4'h0;
      fwd_rst_q <= 1'b0;
      link_run_q <= 1'b0;
      pending_q <= 1'b0;
      req_q <= 1'b0;
      snap_q <= '0;
    end else begin
      sw_rst_q <= sw_rst_d;
      res_bit_q <= res_bit_d;
      gain_low_q <= gain_low_d;
      gain_mid_q <= gain_mid_d;
      gain_high_q <= gain_high_d;
      pin_low_cnt_q <= pin_low_cnt_d;
      fwd_rst_q <= fwd_rst_d;
      link_run_q <= link_run_d;
      pending_q <= pending_d;
      req_q <= req_d;
      snap_q <= snap_d;
    end
  end

  // Crossings to and from the oscillator domain
  logic link_nrst;
  logic ack_toggle;

  // Reset for the link side; it owns no reset of its own to start from
  bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_link_rst_sync (
    .i_clk(i_fwd_osc),
    .i_nrst(1'b1),
    .i_async(link_run_q),
    .o_sync(link_nrst)
  );

  bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_ack_sync (
    .i_clk(i_mclk),
    .i_nrst(i_nrst),
    .i_async(ack_toggle),
    .o_sync(ack_s)
  );

  link_shifter u_link_shifter (
    .i_osc_clk(i_fwd_osc),
    .i_link_nrst(link_nrst),
    .i_req_toggle(req_q),
    .i_word(snap_q),
    .o_ack_toggle(ack_toggle),
    .o_link_clock(o_forward_link_clock),
    .o_link_data(o_forward_link_data)
  );

  // Select drives the gain stage reset directly
  assign o_forward_link_select = fwd_rst_q;
  assign o_forward_busy = pending_q | busy;
  assign o_time_gain_mode = gain_low_q[MODE_BIT];
  assign o_gain_word = {gain_high_q[7:0], gain_mid_q, gain_low_q};
endmodule
`default_nettype wire

/* hdl/link_shifter.sv */
// Link side shifter: sends one 40-bit word per request toggle, LSB first.
// Assumes i_word is held stable from the request toggle until the ack toggle.
`timescale 1ns/1ps
`default_nettype none
module link_shifter (
  // Oscillator clock and reset
  input wire logic i_osc_clk,
  input wire logic i_link_nrst,
  // Request from main domain
  input wire logic i_req_toggle,
  input wire logic [gain_fwd_pkg::WORD_BITS-1:0] i_word,
  output logic o_ack_toggle,
  // Link pins
  output logic o_link_clock,
  output logic o_link_data
);
  import gain_fwd_pkg::*;

  logic req_s;
  link_state_t state_q;
  link_state_t state_d;
  logic seen_q;
  logic seen_d;
  logic ack_q;
  logic ack_d;
  logic gate_q;
  logic gate_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [WORD_BITS-1:0] shreg_q;
  logic [WORD_BITS-1:0] shreg_d;

  bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_req_sync (
    .i_clk(i_osc_clk),
    .i_nrst(i_link_nrst),
    .i_async(i_req_toggle),
    .o_sync(req_s)
  );

  always_comb begin
    state_d = state_q;
    seen_d = seen_q;
    ack_d = ack_q;
    gate_d = gate_q;
    cnt_d = cnt_q;
    shreg_d = shreg_q;
    case (state_q)
      LINK_IDLE: begin
        if (req_s != seen_q) begin
          seen_d = req_s;
          shreg_d = i_word;
          cnt_d = 6'h00;
          gate_d = 1'b1;
          state_d = LINK_SHIFT;
        end
      end
      LINK_SHIFT: begin
        // Zeros shift in, so data idles low after the last bit
        shreg_d = {1'b0, shreg_q[WORD_BITS-1:1]};
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == LINK_LAST_BIT) begin
          gate_d = 1'b0;
          ack_d = ~ack_q;
          state_d = LINK_IDLE;
        end
      end
      default: begin
        state_d = LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_osc_clk) begin
    if (!i_link_nrst) begin
      state_q <= LINK_IDLE;
      seen_q <= 1'b0;
      ack_q <= 1'b0;
      gate_q <= 1'b0;
      cnt_q <= 6'h00;
      shreg_q <= '0;
    end else begin
      state_q <= state_d;
      seen_q <= seen_d;
      ack_q <= ack_d;
      gate_q <= gate_d;
      cnt_q <= cnt_d;
      shreg_q <= shreg_d;
    end
  end

  // Gate changes only while the inverted oscillator is low, so no runt pulses
  assign o_link_clock = gate_q & ~i_osc_clk;
  assign o_link_data = shreg_q[0];
  assign o_ack_toggle = ack_q;
endmodule
`default_nettype wire

/* verif/gain_fwd_props.sv */
// Port checker for the gain stage forwarder.
// Bound from tb_top; sees only the top module ports.
`timescale 1ns/1ps
`default_nettype none
module gain_fwd_props (
  // Clocks and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_fwd_osc,
  // Pin reset
  input wire logic i_adc_reset_n,
  // Outputs watched
  input wire logic o_forward_link_clock,
  input wire logic o_forward_link_data,
  input wire logic o_forward_link_select,
  input wire logic o_forward_busy,
  input wire logic o_time_gain_mode,
  input wire logic [gain_fwd_pkg::WORD_BITS-1:0] o_gain_word
);
  import gain_fwd_pkg::*;
  logic [5:0] run_q;
  // Sampled value avoids the race with the gated clock itself
  // Cleared in reset, so the unknown gated clock before link reset cannot count
  always_ff @(posedge i_fwd_osc) begin
    if (!i_nrst) begin
      run_q <= 6'h00;
    end else begin
      run_q <= $sampled(o_forward_link_clock) ? run_q + 6'h01 : 6'h00;
    end
  end
  sequence s_sel_held;
    o_forward_link_select [*8] ##1 o_forward_link_select [*8];
  endsequence
  sequence s_pin_low;
    !i_adc_reset_n [*3];
  endsequence
  property p_idle_quiet;
    @(posedge i_mclk) disable iff (!i_nrst) !o_forward_busy |-> !o_forward_link_clock && !o_forward_link_data;
  endproperty
  property p_quiet_in_reset;
    @(posedge i_mclk) disable iff (!i_nrst) s_sel_held |-> !o_forward_link_clock && !o_forward_link_data;
  endproperty
  property p_burst_len;
    @(posedge i_fwd_osc) disable iff (!i_nrst || o_forward_link_select)
      !o_forward_link_clock && (run_q != 6'h00) |-> run_q == 6'h28;
  endproperty
  property p_word_fixed;
    @(posedge i_mclk) disable iff (!i_nrst)
      o_gain_word[1:0] == 2'b11 && o_time_gain_mode == o_gain_word[MODE_BIT];
  endproperty
  property p_default_held;
    @(posedge i_mclk) disable iff (!i_nrst) o_forward_link_select [*4] |-> o_gain_word == 40'h0000000023;
  endproperty
  property p_pin_reset;
    @(posedge i_mclk) disable iff (!i_nrst) s_pin_low |-> ##[0:4] o_forward_link_select;
  endproperty
  property p_busy_bounded;
    @(posedge i_mclk) disable iff (!i_nrst || o_forward_link_select)
      $rose(o_forward_busy) |-> ##[1:400] !o_forward_busy;
  endproperty
  property p_link_starts;
    @(posedge i_mclk) disable iff (!i_nrst || o_forward_link_select)
      $rose(o_forward_busy) |-> ##[1:24] o_forward_link_clock;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("link active while idle");
  a_quiet_in_reset: assert property (p_quiet_in_reset) else $error("link toggles in reset");
  a_burst_len: assert property (p_burst_len) else $error("burst length wrong");
  a_word_fixed: assert property (p_word_fixed) else $error("fixed bits or mode wrong");
  a_default_held: assert property (p_default_held) else $error("word not default in reset");
  a_pin_reset: assert property (p_pin_reset) else $error("select not raised by pin");
  a_busy_bounded: assert property (p_busy_bounded) else $error("transfer never ends");
  a_link_starts: assert property (p_link_starts) else $error("transfer never starts");
endmodule
`default_nettype wire

/* verif/host_serial_model.sv */
// Host controller model for the three-wire serial register port.
// Assumes the block samples these pins with a much faster main clock.
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  // Timing reference
  input wire logic i_mclk,
  // Serial port pins
  output logic o_sen_n,
  output logic o_sclk,
  output logic o_sdata
);
  initial begin
    o_sen_n = 1'b1;
    o_sclk = 1'b0;
    o_sdata = 1'b0;
  end
  // Five cycles a phase leaves margin over the two-stage sampler
  task automatic tick();
    repeat (5) @(posedge i_mclk);
    #1;
  endtask
  // MSB first; data released to its inverse when deselected
  task automatic send(input logic [47:0] bits, input int n);
    tick();
    o_sen_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_sdata = bits[47-i];
      tick();
      o_sclk = 1'b1;
      tick();
      o_sclk = 1'b0;
    end
    tick();
    o_sen_n = 1'b1;
    o_sdata = ~o_sdata;
    tick();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    send({a, d, 24'h000000}, 24);
  endtask
  task automatic stream(input logic [15:0] d16, input logic [15:0] d17, input logic [7:0] d18);
    send({gain_fwd_pkg::ADDR_GAIN_LOW, d16, d17, d18}, 48);
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the gain stage forwarder.
// Assumes the host model on the serial port and a free running oscillator.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gain_fwd_pkg::*;
  logic i_mclk, i_nrst, i_fwd_osc, i_adc_reset_n, sen_n, sclk, sdata;
  logic link_clock, link_data, link_select, busy, mode;
  logic [WORD_BITS-1:0] word, shift_q, last_word, exp_w;
  int nrise = 0, nxfer = 0, nx0 = 0, err_count = 0, samples_checked = 0;
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    i_fwd_osc = 1'b0;
    #3.3;
    forever #7.5 i_fwd_osc = ~i_fwd_osc;
  end
  host_serial_model host (.i_mclk(i_mclk), .o_sen_n(sen_n), .o_sclk(sclk), .o_sdata(sdata));
  gain_stage_shadow_forwarder dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_sen_n(sen_n), .i_sclk(sclk), .i_sdata(sdata),
    .i_adc_reset_n(i_adc_reset_n), .i_fwd_osc(i_fwd_osc),
    .o_forward_link_clock(link_clock), .o_forward_link_data(link_data),
    .o_forward_link_select(link_select), .o_forward_busy(busy),
    .o_time_gain_mode(mode), .o_gain_word(word)
  );
  // Gather forwarded bits LSB first; gated clock is unknown until the link side resets
  always @(posedge link_clock) begin
    if (i_nrst) begin
      shift_q = {link_data, shift_q[WORD_BITS-1:1]};
      nrise++;
      if (nrise % WORD_BITS == 0) begin
        last_word = shift_q;
        nxfer++;
      end
    end
  end
  // Select is the far stage's reset input, which returns it to its default word
  always @(posedge link_select) begin
    last_word = {GAIN_HIGH_RST[7:0], GAIN_MID_RST, GAIN_LOW_RST};
  end
  task automatic fail(input string m);
    err_count++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk_word(input logic [WORD_BITS-1:0] got, input logic [WORD_BITS-1:0] exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask
  task automatic chk_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) fail($sformatf("transfers %0d expected %0d", got, exp));
  endtask
  task automatic expect_state(input int n_new);
    int i;
    repeat (12) @(posedge i_mclk);
    for (i = 0; i < 600 && busy !== 1'b0; i++) @(posedge i_mclk);
    #1;
    if (i == 600) fail("busy stuck");
    chk_cnt(nxfer - nx0, n_new);
    chk_word(word, exp_w);
    if (n_new > 0) chk_word(last_word, exp_w);
    nx0 = nxfer;
  endtask
  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
  initial begin
    i_nrst = 1'b0;
    i_adc_reset_n = 1'b1;
    exp_w = 40'h0000000023;
    // Long enough for the oscillator side to see reset too
    repeat (8) @(posedge i_mclk);
    #1;
    i_nrst = 1'b1;
    repeat (4) @(posedge i_mclk);
    #1;
    chk_word(word, exp_w);
    chk_bit(mode, 1'b1);
    chk_bit(link_select, 1'b0);
    host.wr(ADDR_GAIN_MID, 16'ha5c3);
    exp_w = 40'h00a5c30023;
    expect_state(1);
    host.wr(ADDR_GAIN_LOW, 16'h1214);
    exp_w = 40'h00a5c31217;
    expect_state(1);
    chk_bit(mode, 1'b0);
    host.wr(ADDR_GAIN_LOW, 16'h1214);
    expect_state(0);
    host.wr(8'h20, 16'h00ff);
    expect_state(0);
    host.stream(16'hbeec, 16'h0f0f, 8'h5a);
    exp_w = 40'h5a0f0fbeef;
    expect_state(3);
    chk_bit(mode, 1'b1);
    host.wr(ADDR_GAIN_RESET_CTRL, 16'h0020);
    exp_w = 40'h0000000023;
    repeat (8) @(posedge i_mclk);
    #1;
    chk_bit(link_select, 1'b1);
    host.wr(ADDR_GAIN_MID, 16'h7777);
    expect_state(0);
    chk_bit(link_select, 1'b1);
    host.wr(ADDR_GAIN_RESET_CTRL, 16'h0000);
    expect_state(0);
    chk_bit(link_select, 1'b0);
    host.wr(ADDR_GAIN_MID, 16'h7777);
    exp_w = 40'h0077770023;
    expect_state(1);
    host.wr(ADDR_GAIN_RESET_CTRL, 16'h0020);
    host.wr(ADDR_SOFT_RESET, 16'h0001);
    exp_w = 40'h0000000023;
    expect_state(0);
    chk_bit(link_select, 1'b0);
    host.wr(ADDR_GAIN_LOW, 16'h0020);
    expect_state(0);
    host.wr(ADDR_GAIN_HIGH, 16'h0001);
    exp_w = 40'h0100000023;
    expect_state(1);
    i_adc_reset_n = 1'b0;
    repeat (6) @(posedge i_mclk);
    #1;
    chk_bit(link_select, 1'b1);
    i_adc_reset_n = 1'b1;
    exp_w = 40'h0000000023;
    expect_state(0);
    chk_bit(link_select, 1'b0);
    chk_word(last_word, exp_w);
    print_verdict();
  end
endmodule
bind gain_stage_shadow_forwarder gain_fwd_props u_props (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_fwd_osc(i_fwd_osc), .i_adc_reset_n(i_adc_reset_n),
  .o_forward_link_clock(o_forward_link_clock), .o_forward_link_data(o_forward_link_data),
  .o_forward_link_select(o_forward_link_select), .o_forward_busy(o_forward_busy),
  .o_time_gain_mode(o_time_gain_mode), .o_gain_word(o_gain_word)
);
`default_nettype wire
